/* File: bdgs_host_model.sv */
/* Host bus model: one I/O cycle at a time.
   Assumes the bench calls io_cyc just after a falling edge. */
`timescale 1ns/1ns
`default_nettype none
module bdgs_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] host_data_out,
    output var  logic [9:0] host_addr,
    output var  logic       host_ior_b,
    output var  logic       host_iow_b,
    output var  logic       host_aen,
    output var  logic [7:0] host_data_in
);
    initial
    begin
        host_addr = 10'h000;
        host_ior_b = 1'b1;
        host_iow_b = 1'b1;
        host_aen = 1'b0;
        host_data_in = 8'h00;
    end
    // Strobe low six clocks, lines held four more
    task automatic io_cyc(input logic [9:0] a, input logic [7:0] d, input logic wr,
                          input logic aen, output logic [7:0] q);
        @(negedge core_clk);
        host_addr = a;
        host_aen = aen;
        host_data_in = d;
        host_iow_b = !wr;
        host_ior_b = wr;
        repeat (6) @(negedge core_clk);
        q = host_data_out;
        host_iow_b = 1'b1;
        host_ior_b = 1'b1;
        repeat (4) @(negedge core_clk);
        host_data_in = ~d;
        host_aen = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: bdgs_pkg.sv */
/*
 Constants for the board decode and gain store block: address fields,
 register offsets, reset values and gain-code layout.
 Assumes a byte-wide host I/O bus with ten address lines.
*/
`default_nettype none
package bdgs_pkg;
    localparam int unsigned ADDR_W       = 10;
    localparam int unsigned BASE_LSB     = 5;
    localparam int unsigned BASE_W       = 5;
    localparam int unsigned SEL_W        = 5;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned IRQ_W        = 8;
    localparam int unsigned CODE_W       = 2;
    localparam int unsigned CODES_PER_B  = 4;
    localparam int unsigned GAIN_ENTRIES = 8;
    localparam int unsigned CHAN_W       = 4;
    localparam logic [4:0] OFS_GAIN_LOW  = 5'h04;
    localparam logic [4:0] OFS_GAIN_HIGH = 5'h05;
    localparam logic [4:0] OFS_IRQ_CTRL  = 5'h1A;
    localparam logic [4:0] OFS_JMP_STAT  = 5'h1B;
    localparam logic [7:0] GAIN_RST      = 8'h00;
    localparam logic       IRQ_EN_RST    = 1'h0;
    localparam int unsigned IRQ_EN_BIT   = 0;
endpackage
`default_nettype wire

/* File: bdgs_sync.sv */
/*
 Two-flop synchroniser, one per bit, for jumper and pin levels.
 Assumes core_clk domain; first stage read only by the second.
*/
`timescale 1ns/1ns
`default_nettype none
module bdgs_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] nxt_stage1;
    logic [W-1:0] nxt_sync;

    always_comb
    begin
        nxt_stage1 = stage1_ff;
        nxt_sync   = sync_out;
        if (!rst_b)
        begin
            nxt_stage1 = '0;
            nxt_sync   = '0;
        end
        else if (clk_en)
        begin
            nxt_stage1 = async_in;
            nxt_sync   = stage1_ff;
        end
    end

    always_ff @(posedge core_clk)
    begin
        stage1_ff <= nxt_stage1;
        sync_out  <= nxt_sync;
    end
endmodule
`default_nettype wire

/* File: bdgs_top.sv */
/*
 Board address decode, FIFO half-full interrupt routing, per-channel gain
 code store and analog jumper sensing.
 Assumes host strobes, address and jumpers are asynchronous to core_clk and
 are held for several core_clk periods per I/O cycle.
*/
// Function
// - Compare A9..A5 with five base jumpers; claim only on full match.
// - Occupy thirty-two byte addresses aligned at the jumper base.
// - Low lines A4..A0 choose the register inside the block.
// - Open jumper reads one, fitted jumper reads zero.
// - Raise interrupt at FIFO half full when software enabled.
// - Drive only the jumper-chosen IRQ line; none chosen, none driven.
// - Offset 04 holds gain codes of channels zero to three.
// - Offset 05 holds gain codes of channels four to seven.
// - Channels eight to fifteen reuse gain of channel minus eight.
// - Every gain code resets to zero, unity gain.
// - Gain code has four values within the jumper-selected row.
// - Sense tattletale jumper of span and mux-mode pairs.
// - Mux jumper selects sixteen single-ended or eight differential.
`timescale 1ns/1ns
`default_nettype none
module bdgs_top (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [9:0]  host_addr,
    input  wire logic        host_ior_b,
    input  wire logic        host_iow_b,
    input  wire logic        host_aen,
    input  wire logic [7:0]  host_data_in,
    output var  logic [7:0]  host_data_out,
    output var  logic        host_data_oe,
    output var  logic        board_select,
    input  wire logic [4:0]  base_jumper_open,
    input  wire logic [7:0]  irq_jumper,
    input  wire logic        fifo_half_full,
    output var  logic [7:0]  irq_out,
    output var  logic [7:0]  irq_oe,
    input  wire logic        wide_span_select,
    input  wire logic        narrow_span_select,
    input  wire logic        bipolar_select,
    input  wire logic        single_ended_sixteen,
    input  wire logic        differential_eight,
    input  wire logic [3:0]  conv_channel,
    output var  logic [1:0]  conv_gain_code,
    output var  logic        conv_channel_valid,
    output var  logic        span_is_wide,
    output var  logic        span_is_bipolar,
    output var  logic        mux_differential,
    output var  logic        jumper_fault
);
    // Synchronised pins
    logic [9:0] addr_s;
    logic       rd_s;
    logic       wr_s;
    logic       cyc_s;
    logic [7:0] din_s;
    logic [4:0] base_s;
    logic [7:0] irqj_s;
    logic       half_s;
    logic [4:0] jmp_s;

    bdgs_sync #(.W(34)) u_sync_bus (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        // Strobes and AEN inverted so a cleared chain reads as an idle bus
        .async_in ({host_addr, ~host_ior_b, ~host_iow_b, ~host_aen, host_data_in,
                    base_jumper_open, irq_jumper}),
        .sync_out ({addr_s, rd_s, wr_s, cyc_s, din_s, base_s, irqj_s})
    );

    // Jumper levels and FIFO flag
    bdgs_sync #(.W(6)) u_sync_misc (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in ({fifo_half_full, wide_span_select, narrow_span_select,
                    bipolar_select, single_ended_sixteen, differential_eight}),
        .sync_out ({half_s, jmp_s})
    );

    // Decode
    logic       hit;
    logic [4:0] sel;
    logic       wr_edge;
    logic       rd_act;

    // Open jumper gives one, fitted gives zero: compare bit equals jumper level
    assign hit = cyc_s
        && (addr_s[bdgs_pkg::BASE_LSB +: bdgs_pkg::BASE_W] == base_s);
    assign sel = addr_s[bdgs_pkg::SEL_W-1:0];

    // Register state
    logic [7:0] gain_lo_ff;
    logic [7:0] gain_hi_ff;
    logic       irq_en_ff;
    logic       wr_d_ff;
    logic [7:0] nxt_gain_lo;
    logic [7:0] nxt_gain_hi;
    logic       nxt_irq_en;
    logic       nxt_wr_d;

    // Write taken once, at the trailing edge of the write strobe
    assign wr_edge = hit && !wr_s && wr_d_ff;
    assign rd_act  = hit && rd_s;

    always_comb
    begin
        nxt_gain_lo = gain_lo_ff;
        nxt_gain_hi = gain_hi_ff;
        nxt_irq_en  = irq_en_ff;
        nxt_wr_d    = wr_s;
        // Unmapped and read-only offsets change nothing
        if (wr_edge)
        begin
            case (sel)
                bdgs_pkg::OFS_GAIN_LOW:  nxt_gain_lo = din_s;
                bdgs_pkg::OFS_GAIN_HIGH: nxt_gain_hi = din_s;
                bdgs_pkg::OFS_IRQ_CTRL:  nxt_irq_en  = din_s[bdgs_pkg::IRQ_EN_BIT];
                default:                 nxt_gain_lo = gain_lo_ff;
            endcase
        end
        if (!rst_b)
        begin
            nxt_gain_lo = bdgs_pkg::GAIN_RST;
            nxt_gain_hi = bdgs_pkg::GAIN_RST;
            nxt_irq_en  = bdgs_pkg::IRQ_EN_RST;
            nxt_wr_d    = 1'h0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (clk_en || !rst_b)
        begin
            gain_lo_ff <= nxt_gain_lo;
            gain_hi_ff <= nxt_gain_hi;
            irq_en_ff  <= nxt_irq_en;
            wr_d_ff    <= nxt_wr_d;
        end
    end

    // Gain lookup
    logic [15:0] gain_all;
    logic [1:0]  gain_tab [bdgs_pkg::GAIN_ENTRIES];
    logic [2:0]  entry;
    assign gain_all = {gain_hi_ff, gain_lo_ff};

    // Eight two-bit codes, channel k at bits 2k+1 down to 2k
    genvar gi;
    generate
        for (gi = 0; gi < bdgs_pkg::GAIN_ENTRIES; gi++)
        begin : g_gain
            assign gain_tab[gi] = gain_all[2*gi +: bdgs_pkg::CODE_W];
        end
    endgenerate

    // In differential mode only channels 0..7 exist
    assign entry = conv_channel[2:0];

    // Host read path
    logic [7:0] dout_ff;
    logic       doe_ff;
    logic       sel_ff;
    logic [7:0] nxt_dout;
    logic       nxt_doe;
    logic       nxt_sel;

    always_comb
    begin
        nxt_sel = hit;
        nxt_doe = rd_act;
        case (sel)
            bdgs_pkg::OFS_GAIN_LOW:  nxt_dout = gain_lo_ff;
            bdgs_pkg::OFS_GAIN_HIGH: nxt_dout = gain_hi_ff;
            bdgs_pkg::OFS_IRQ_CTRL:  nxt_dout = {7'h00, irq_en_ff};
            bdgs_pkg::OFS_JMP_STAT:  nxt_dout = {2'h0, half_s, jmp_s};
            default:                 nxt_dout = 8'h00;
        endcase
        if (!rst_b)
        begin
            nxt_sel  = 1'h0;
            nxt_doe  = 1'h0;
            nxt_dout = 8'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (clk_en || !rst_b)
        begin
            dout_ff <= nxt_dout;
            doe_ff  <= nxt_doe;
            sel_ff  <= nxt_sel;
        end
    end

    // Interrupt routing, one request line per jumper position
    logic [7:0] irq_ff;
    logic [7:0] irq_oe_ff;
    logic [7:0] nxt_irq;
    logic [7:0] nxt_irq_oe;
    logic [7:0] line_alone;
    logic       req;

    // A line is routed only while it is the single fitted jumper
    genvar li;
    generate
        for (li = 0; li < bdgs_pkg::IRQ_W; li++)
        begin : g_irq_line
            assign line_alone[li] = (irqj_s == (8'h01 << li));
        end
    endgenerate

    always_comb
    begin
        req        = irq_en_ff && half_s;
        nxt_irq_oe = line_alone;
        nxt_irq    = req ? line_alone : 8'h00;
        if (!rst_b)
        begin
            nxt_irq    = 8'h00;
            nxt_irq_oe = 8'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (clk_en || !rst_b)
        begin
            irq_ff    <= nxt_irq;
            irq_oe_ff <= nxt_irq_oe;
        end
    end

    // Conversion gain and analog jumper state
    logic [1:0] gcode_ff;
    logic       cvalid_ff;
    logic       wide_ff;
    logic       bip_ff;
    logic       diff_ff;
    logic       fault_ff;
    logic [1:0] nxt_gcode;
    logic       nxt_cvalid;
    logic       nxt_wide;
    logic       nxt_bip;
    logic       nxt_diff;
    logic       nxt_fault;
    logic       diff_sel;

    // Differential only with its jumper set and the single-ended one clear
    assign diff_sel = jmp_s[0] && !jmp_s[1];

    always_comb
    begin
        nxt_wide   = jmp_s[4];
        nxt_bip    = jmp_s[2];
        nxt_diff   = diff_sel;
        nxt_fault  = (jmp_s[4] == jmp_s[3]) || (jmp_s[1] == jmp_s[0]);
        nxt_gcode  = gain_tab[entry];
        nxt_cvalid = !(diff_sel && conv_channel[3]);
        if (!rst_b)
        begin
            nxt_wide   = 1'h0;
            nxt_bip    = 1'h0;
            nxt_diff   = 1'h0;
            nxt_fault  = 1'h0;
            nxt_gcode  = 2'h0;
            nxt_cvalid = 1'h0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (clk_en || !rst_b)
        begin
            gcode_ff  <= nxt_gcode;
            cvalid_ff <= nxt_cvalid;
            wide_ff   <= nxt_wide;
            bip_ff    <= nxt_bip;
            diff_ff   <= nxt_diff;
            fault_ff  <= nxt_fault;
        end
    end

    assign host_data_out      = dout_ff;
    assign host_data_oe       = doe_ff;
    assign board_select       = sel_ff;
    assign irq_out            = irq_ff;
    assign irq_oe             = irq_oe_ff;
    assign conv_gain_code     = gcode_ff;
    assign conv_channel_valid = cvalid_ff;
    assign span_is_wide       = wide_ff;
    assign span_is_bipolar    = bip_ff;
    assign mux_differential   = diff_ff;
    assign jumper_fault       = fault_ff;
endmodule
`default_nettype wire

/* File: bdgs_top_properties.sv */
/* Port checker for bdgs_top.
   Assumes clk_en high and jumpers steady for several clocks. */
`timescale 1ns/1ns
`default_nettype none
module bdgs_top_checker (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic [9:0] host_addr,
    input wire logic       host_ior_b,
    input wire logic       host_iow_b,
    input wire logic       host_aen,
    input wire logic       board_select,
    input wire logic [4:0] base_jumper_open,
    input wire logic       host_data_oe,
    input wire logic [7:0] irq_jumper,
    input wire logic [7:0] irq_oe,
    input wire logic [7:0] irq_out,
    input wire logic       fifo_half_full,
    input wire logic [3:0] conv_channel,
    input wire logic [1:0] conv_gain_code,
    input wire logic       conv_channel_valid,
    input wire logic       mux_differential
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_hit; board_select |-> $past(host_addr[9:5], 3) == $past(base_jumper_open, 3);
    endproperty
    a_hit: assert property (p_hit) else $error("select without match");
    property p_aen; host_aen [*4] |-> !board_select; endproperty
    a_aen: assert property (p_aen) else $error("select during dma");
    property p_oe; host_data_oe |-> board_select && !$past(host_ior_b, 3); endproperty
    a_oe: assert property (p_oe) else $error("stray read drive");
    property p_rd; $fell(host_ior_b) ##0 !host_ior_b [*4] ##0 board_select |-> host_data_oe;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_line; $stable(irq_jumper) [*4] |-> $onehot0(irq_oe) && !(irq_oe & ~irq_jumper);
    endproperty
    a_line: assert property (p_line) else $error("wrong irq line");
    property p_hf; !fifo_half_full [*4] |-> irq_out == 8'h00; endproperty
    a_hf: assert property (p_hf) else $error("irq without half full");
    property p_valid; $past(rst_b, 2) && $stable(mux_differential) |->
        conv_channel_valid == (!mux_differential || $past(conv_channel) < 4'h8); endproperty
    a_valid: assert property (p_valid) else $error("channel valid wrong");
    property p_pair; (host_iow_b && !mux_differential) [*6] ##0
        conv_channel == ($past(conv_channel) ^ 4'h8) |=> $stable(conv_gain_code); endproperty
    a_pair: assert property (p_pair) else $error("gain alias differs");
endmodule
bind bdgs_top bdgs_top_checker bdgs_top_checker_inst (.core_clk, .rst_b, .host_addr,
    .host_ior_b, .host_iow_b, .host_aen, .board_select, .base_jumper_open, .host_data_oe,
    .irq_jumper, .irq_oe, .irq_out, .fifo_half_full, .conv_channel, .conv_gain_code,
    .conv_channel_valid, .mux_differential);
`default_nettype wire

/* File: test_board_decode_gain_store.sv */
/* Bench for bdgs_top with host model; jumpers and channel driven here.
   Assumes checker and host model compiled first. */
`timescale 1ns/1ns
`default_nettype none
module test_board_decode_gain_store;
    logic core_clk = 1'b0, rst_b = 1'b0, fifo_half_full = 1'b0, bipolar_select = 1'b0;
    logic wide_span_select = 1'b1, narrow_span_select = 1'b0;
    logic single_ended_sixteen = 1'b1, differential_eight = 1'b0;
    logic host_ior_b, host_iow_b, host_aen, host_data_oe, board_select, conv_channel_valid;
    logic span_is_wide, span_is_bipolar, mux_differential, jumper_fault;
    logic [9:0] host_addr;
    logic [7:0] host_data_in, host_data_out, irq_out, irq_oe, q, irq_jumper = 8'h20;
    logic [4:0] base_jumper_open = 5'h16;
    logic [3:0] conv_channel = 4'h0;
    logic [1:0] conv_gain_code;
    int fail_count = 0, n_compared = 0, cycles = 0;
    bdgs_top bdgs_top_inst (.core_clk, .rst_b, .clk_en(1'b1), .host_addr, .host_ior_b,
        .host_iow_b, .host_aen, .host_data_in, .host_data_out, .host_data_oe, .board_select,
        .base_jumper_open, .irq_jumper, .fifo_half_full, .irq_out, .irq_oe,
        .wide_span_select, .narrow_span_select, .bipolar_select, .single_ended_sixteen,
        .differential_eight, .conv_channel, .conv_gain_code, .conv_channel_valid,
        .span_is_wide, .span_is_bipolar, .mux_differential, .jumper_fault);
    bdgs_host_model bdgs_host_model_inst (.core_clk, .host_data_out, .host_addr,
        .host_ior_b, .host_iow_b, .host_aen, .host_data_in);
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic io(input logic [4:0] ofs, input logic [7:0] d, input logic wr);
        bdgs_host_model_inst.io_cyc({base_jumper_open, ofs}, d, wr, 1'b0, q);
        repeat (4) @(negedge core_clk);
    endtask
    task automatic t_gain;
        io(5'h04, 8'h00, 1'b0);
        check(q, 8'h00);
        io(5'h04, 8'h1B, 1'b1);
        io(5'h05, 8'hE4, 1'b1);
        io(5'h04, 8'h00, 1'b0);
        check(q, 8'h1B);
        io(5'h05, 8'h00, 1'b0);
        check(q, 8'hE4);
        for (int c = 0; c < 16; c++)
        begin
            conv_channel = 4'(c);
            repeat (3) @(negedge core_clk);
            check(8'(conv_gain_code), 8'(16'hE41B >> (c % 8 * 2)) & 8'h03);
            check(8'(conv_channel_valid), 8'h01);
        end
        // Channel 15 then 7: bit 3 alone toggles, same entry
        conv_channel = 4'h7;
        repeat (3) @(negedge core_clk);
        check(8'(conv_gain_code), 8'h03);
        $display("gain test done");
    endtask
    task automatic t_decode;
        bdgs_host_model_inst.io_cyc({base_jumper_open ^ 5'h01, 5'h04}, 8'h55, 1'b1, 1'b0, q);
        bdgs_host_model_inst.io_cyc({base_jumper_open, 5'h04}, 8'h66, 1'b1, 1'b1, q);
        io(5'h1F, 8'h77, 1'b1);
        io(5'h1F, 8'h00, 1'b0);
        check(q, 8'h00);
        io(5'h04, 8'h00, 1'b0);
        check(q, 8'h1B);
        base_jumper_open = 5'h09;
        io(5'h04, 8'h33, 1'b1);
        bdgs_host_model_inst.io_cyc(10'h124, 8'h00, 1'b0, 1'b0, q);
        check(q, 8'h33);
        $display("decode test done");
    endtask
    task automatic t_irq;
        fifo_half_full = 1'b1;
        io(5'h1A, 8'h01, 1'b1);
        check(irq_oe, 8'h20);
        check(irq_out, 8'h20);
        fifo_half_full = 1'b0;
        repeat (5) @(negedge core_clk);
        check(irq_out, 8'h00);
        fifo_half_full = 1'b1;
        irq_jumper = 8'h22;
        repeat (5) @(negedge core_clk);
        check(irq_oe, 8'h00);
        check(irq_out, 8'h00);
        irq_jumper = 8'h20;
        io(5'h1A, 8'h00, 1'b1);
        check(irq_out, 8'h00);
        irq_jumper = 8'h00;
        repeat (5) @(negedge core_clk);
        check(irq_oe, 8'h00);
        $display("irq test done");
    endtask
    task automatic t_jumper;
        single_ended_sixteen = 1'b0;
        differential_eight = 1'b1;
        bipolar_select = 1'b1;
        conv_channel = 4'h9;
        repeat (5) @(negedge core_clk);
        check(8'(conv_channel_valid), 8'h00);
        check(8'({mux_differential, span_is_wide, span_is_bipolar, jumper_fault}), 8'h0E);
        io(5'h1B, 8'h00, 1'b0);
        check(q, 8'h35);
        conv_channel = 4'h1;
        repeat (3) @(negedge core_clk);
        check(8'(conv_channel_valid), 8'h01);
        narrow_span_select = 1'b1;
        repeat (5) @(negedge core_clk);
        check(8'(jumper_fault), 8'h01);
        $display("jumper test done");
    endtask
    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        t_gain();
        t_decode();
        t_irq();
        t_jumper();
        end_sim();
    end
endmodule
`default_nettype wire
